// ===== include/pia_pkg.sv
// Package of constants for the prioritized interrupt arbiter.
`default_nettype none
package pia_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_SRC = 66;
    localparam int VEC_W = 7;
    localparam int ADDR_W = 24;
    localparam int NUM_PRIO_WORDS = 5;
    localparam int SRC_PER_WORD = 16;
    // ==========================================================
    // Priority field codes: disabled, then levels 0, 1 and 2.
    localparam logic [1:0] PRIO_DIS = 2'h0;
    localparam logic [1:0] PRIO_LVL0 = 2'h1;
    localparam logic [1:0] PRIO_LVL2 = 2'h3;
    localparam logic [1:0] PRIO_RESET = 2'h0;
    // Sources whose priority hardware fixes, and the fixed code.
    localparam logic [NUM_SRC-1:0] FIXED_MASK = 66'h0;
    localparam logic [1:0] FIXED_PRIO = 2'h3;
    // Each vector table entry is two words wide.
    localparam int VEC_SHIFT = 1;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_PRIO0 = 8'h00;
    localparam logic [7:0] OFS_FAST0_MATCH = 8'h14;
    localparam logic [7:0] OFS_FAST1_MATCH = 8'h18;
    localparam logic [7:0] OFS_FAST0_LOW = 8'h1C;
    localparam logic [7:0] OFS_FAST0_HIGH = 8'h20;
    localparam logic [7:0] OFS_FAST1_LOW = 8'h24;
    localparam logic [7:0] OFS_FAST1_HIGH = 8'h28;
    localparam logic [7:0] OFS_VBA = 8'h2C;
    localparam logic [7:0] OFS_STATUS = 8'h30;
    // ==========================================================
    // Reset values
    localparam logic [VEC_W-1:0] MATCH_RESET = 7'h7F;
    localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
    localparam logic [7:0] ADDR_HIGH_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] VBA_RESET = 24'h000000;
endpackage : pia_pkg
`default_nettype wire

// ===== src/pia_irq_arbiter.sv
// Prioritized interrupt arbiter with APB registers and fast slots.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`default_nettype none

// Notes on behaviour
// - 66 sources, three levels or disabled each.
// - Per level, lowest active vector number wins.
// - Signal core and present service address.
// - Two fast slots, each matched by vector.
// - Fast only on slot match at level 2.
// - Fast address comes from slot low/high.
// - Fast flagged here before core recognition.
module pia_irq_arbiter
    import pia_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral requests, same clock, level sensitive
    input wire logic [NUM_SRC-1:0] src_irq,
    // Core side
    input wire logic [1:0] core_min_level,
    output logic irq_req,
    output logic irq_fast,
    output logic [1:0] irq_level,
    output logic [VEC_W-1:0] irq_vector,
    output logic [ADDR_W-1:0] irq_addr
);
    // ==========================================================
    // Helpers
    function automatic logic [VEC_W:0] pia_lowest(
        input logic [NUM_SRC-1:0] v);
        logic [VEC_W:0] r;
        r = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, VEC_W'(i)};
            end
        end
        return r;
    endfunction : pia_lowest

    // ==========================================================
    // Register state
    logic [1:0] prio_q [NUM_SRC];
    logic [1:0] prio_d [NUM_SRC];
    logic [VEC_W-1:0] match_q [2];
    logic [VEC_W-1:0] match_d [2];
    logic [15:0] alow_q [2];
    logic [15:0] alow_d [2];
    logic [7:0] ahigh_q [2];
    logic [7:0] ahigh_d [2];
    logic [ADDR_W-1:0] vba_q, vba_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [1:0] prio_eff [NUM_SRC];

    logic access, do_wr, mapped;
    logic [5:0] widx;

    assign access = psel && penable;
    assign do_wr = access && pready_q && pwrite;
    assign widx = paddr[7:2];

    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            prio_eff[i] = FIXED_MASK[i] ? FIXED_PRIO : prio_q[i];
        end
    end

    // ==========================================================
    // Arbitration
    logic [NUM_SRC-1:0] act [3];
    logic [VEC_W:0] win [3];
    logic cand;
    logic [1:0] cand_lvl;
    logic [VEC_W-1:0] cand_vec;
    logic cand_fast;
    logic [ADDR_W-1:0] cand_addr;

    always_comb begin
        for (int l = 0; l < 3; l++) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                // A disabled field matches no level code.
                act[l][i] = src_irq[i] &&
                    (prio_eff[i] == 2'(l + 1));
            end
            win[l] = pia_lowest(act[l]);
        end
        cand = 1'b0;
        cand_lvl = 2'h0;
        cand_vec = '0;
        for (int l = 0; l < 3; l++) begin
            if (win[l][VEC_W]) begin
                cand = 1'b1;
                cand_lvl = 2'(l);
                cand_vec = win[l][VEC_W-1:0];
            end
        end
        cand = cand && (cand_lvl >= core_min_level);
        cand_fast = 1'b0;
        cand_addr = vba_q + (ADDR_W'(cand_vec) << VEC_SHIFT);
        if (cand_lvl == 2'(PRIO_LVL2 - PRIO_LVL0)) begin
            if (cand_vec == match_q[0]) begin
                cand_fast = 1'b1;
                cand_addr = {ahigh_q[0], alow_q[0]};
            end else if (cand_vec == match_q[1]) begin
                cand_fast = 1'b1;
                cand_addr = {ahigh_q[1], alow_q[1]};
            end
        end
    end

    // ==========================================================
    // Core outputs
    logic irq_req_q, irq_req_d, irq_fast_q, irq_fast_d;
    logic [1:0] irq_level_q, irq_level_d;
    logic [VEC_W-1:0] irq_vector_q, irq_vector_d;
    logic [ADDR_W-1:0] irq_addr_q, irq_addr_d;

    always_comb begin
        irq_req_d = cand;
        irq_fast_d = cand && cand_fast;
        irq_level_d = cand ? cand_lvl : 2'h0;
        irq_vector_d = cand ? cand_vec : '0;
        irq_addr_d = cand ? cand_addr : '0;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_req_q <= 1'b0;
            irq_fast_q <= 1'b0;
            irq_level_q <= 2'h0;
            irq_vector_q <= '0;
            irq_addr_q <= '0;
        end else begin
            irq_req_q <= irq_req_d;
            irq_fast_q <= irq_fast_d;
            irq_level_q <= irq_level_d;
            irq_vector_q <= irq_vector_d;
            irq_addr_q <= irq_addr_d;
        end
    end

    // ==========================================================
    // APB slave: one wait state, then a registered answer.
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            prio_d[i] = prio_q[i];
            if (do_wr && widx < 6'(NUM_PRIO_WORDS) &&
                    widx == 6'(i / SRC_PER_WORD) && paddr[1:0] == 2'h0) begin
                prio_d[i] = pwdata[2*(i%SRC_PER_WORD) +: 2];
            end
        end
        for (int s = 0; s < 2; s++) begin
            match_d[s] = match_q[s];
            alow_d[s] = alow_q[s];
            ahigh_d[s] = ahigh_q[s];
        end
        vba_d = vba_q;
        if (do_wr) begin
            case (paddr)
                OFS_FAST0_MATCH: match_d[0] = pwdata[VEC_W-1:0];
                OFS_FAST1_MATCH: match_d[1] = pwdata[VEC_W-1:0];
                OFS_FAST0_LOW: alow_d[0] = pwdata[15:0];
                OFS_FAST0_HIGH: ahigh_d[0] = pwdata[7:0];
                OFS_FAST1_LOW: alow_d[1] = pwdata[15:0];
                OFS_FAST1_HIGH: ahigh_d[1] = pwdata[7:0];
                OFS_VBA: vba_d = pwdata[ADDR_W-1:0];
                default: ;
            endcase
        end
        mapped = 1'b1;
        prdata_d = prdata_q;
        case (paddr)
            OFS_FAST0_MATCH: prdata_d = 32'(match_q[0]);
            OFS_FAST1_MATCH: prdata_d = 32'(match_q[1]);
            OFS_FAST0_LOW: prdata_d = 32'(alow_q[0]);
            OFS_FAST0_HIGH: prdata_d = 32'(ahigh_q[0]);
            OFS_FAST1_LOW: prdata_d = 32'(alow_q[1]);
            OFS_FAST1_HIGH: prdata_d = 32'(ahigh_q[1]);
            OFS_VBA: prdata_d = 32'(vba_q);
            OFS_STATUS: prdata_d = {16'h0000, irq_req_q, irq_fast_q,
                irq_level_q, 5'h00, irq_vector_q};
            default: begin
                prdata_d = 32'h00000000;
                mapped = (paddr[1:0] == 2'h0) &&
                    (widx < 6'(NUM_PRIO_WORDS));
                for (int i = 0; i < NUM_SRC; i++) begin
                    if (widx == 6'(i / SRC_PER_WORD)) begin
                        prdata_d[2*(i%SRC_PER_WORD) +: 2] = prio_eff[i];
                    end
                end
            end
        endcase
        if (!(access && !pready_q) || pwrite) begin
            prdata_d = (access && !pready_q) ? 32'h00000000 : prdata_q;
        end
        if (access && !pready_q && !mapped) begin
            prdata_d = 32'h00000000;
        end
        pready_d = access && !pready_q;
        pslverr_d = access && !pready_q && !mapped;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                prio_q[i] <= PRIO_RESET;
            end
            for (int s = 0; s < 2; s++) begin
                match_q[s] <= MATCH_RESET;
                alow_q[s] <= ADDR_LOW_RESET;
                ahigh_q[s] <= ADDR_HIGH_RESET;
            end
            vba_q <= VBA_RESET;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prio_q <= prio_d;
            match_q <= match_d;
            alow_q <= alow_d;
            ahigh_q <= ahigh_d;
            vba_q <= vba_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq_req = irq_req_q;
    assign irq_fast = irq_fast_q;
    assign irq_level = irq_level_q;
    assign irq_vector = irq_vector_q;
    assign irq_addr = irq_addr_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic [NUM_SRC-1:0] lower_same;
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            lower_same[i] = act[irq_level_q][i] &&
                (VEC_W'(i) < irq_vector_q);
        end
    end

    property p_vec_range;
        irq_req_q |-> irq_vector_q < VEC_W'(NUM_SRC);
    endproperty
    a_vec_range: assert property (p_vec_range)
        else $error("vector out of range");

    property p_lowest;
        irq_req_q && $stable(src_irq) && $stable(irq_level_q)
            |-> lower_same == '0;
    endproperty
    a_lowest: assert property (p_lowest)
        else $error("lower vector at same level was skipped");

    property p_req_follows;
        cand |=> irq_req_q;
    endproperty
    a_req_follows: assert property (p_req_follows)
        else $error("eligible request not signalled");

    property p_sufficient;
        irq_req_q |-> irq_level_q >= $past(core_min_level);
    endproperty
    a_sufficient: assert property (p_sufficient)
        else $error("request below core level");

    property p_fast_cause;
        irq_fast_q |-> irq_level_q == 2'h2 &&
            (irq_vector_q == $past(match_q[0]) ||
             irq_vector_q == $past(match_q[1]));
    endproperty
    a_fast_cause: assert property (p_fast_cause)
        else $error("fast flag without level 2 match");

    property p_fast_addr;
        irq_fast_q && irq_vector_q == $past(match_q[0]) |->
            irq_addr_q == {$past(ahigh_q[0]), $past(alow_q[0])};
    endproperty
    a_fast_addr: assert property (p_fast_addr)
        else $error("fast address not from slot");

    property p_fast_with_req;
        irq_fast_q |-> irq_req_q;
    endproperty
    a_fast_with_req: assert property (p_fast_with_req)
        else $error("fast flag without request");

    property p_norm_addr;
        irq_req_q && !irq_fast_q |-> irq_addr_q ==
            $past(vba_q) + (ADDR_W'(irq_vector_q) << VEC_SHIFT);
    endproperty
    a_norm_addr: assert property (p_norm_addr)
        else $error("normal address not base plus offset");

    // Enabled and active sources, delayed to line up with the winner.
    logic [NUM_SRC-1:0] en_act_q;
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_SRC; i++) begin
            en_act_q[i] <= src_irq[i] && prio_eff[i] != PRIO_DIS;
        end
    end
    property p_no_disabled;
        irq_req_q |-> en_act_q[irq_vector_q];
    endproperty
    a_no_disabled: assert property (p_no_disabled)
        else $error("disabled or idle source requested");

    c_fast: cover property (irq_req_q && irq_fast_q);
    c_normal: cover property (irq_req_q && !irq_fast_q);
    c_level0: cover property (irq_req_q && irq_level_q == 2'h0);
    c_apb_err: cover property (pready_q && pslverr_q);
endmodule : pia_irq_arbiter
`default_nettype wire

// ===== dv/pia_core_model.sv
// Behavioural model of the core that fetches interrupt service vectors.
`default_nettype none
module pia_core_model
    import pia_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Controller side
    input wire logic irq_req,
    input wire logic irq_fast,
    input wire logic [ADDR_W-1:0] irq_addr,
    input wire logic [1:0] level_set,
    output logic [1:0] core_min_level,
    // Observed fetch
    output logic [ADDR_W-1:0] fetch_addr_q,
    output logic fetch_fast_q
);
    timeunit 1ns;
    timeprecision 1ns;
    assign core_min_level = level_set;
    // ==========================================================
    // Fetch
    // A fast request is fetched at the supplied address itself, so the
    // model never adds a table offset of its own.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fetch_addr_q <= '0;
            fetch_fast_q <= 1'b0;
        end else if (irq_req) begin
            fetch_addr_q <= irq_addr;
            fetch_fast_q <= irq_fast;
        end
    end
endmodule : pia_core_model
`default_nettype wire

// ===== dv/tb.sv
// Self-checking testbench for the prioritized interrupt arbiter.
`default_nettype none
module tb
    import pia_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NUM_SRC-1:0] src_irq;
    logic [1:0] lvl, core_min_level, irq_level;
    logic irq_req, irq_fast, fetch_fast;
    logic [VEC_W-1:0] irq_vector;
    logic [ADDR_W-1:0] irq_addr, fetch_addr;
    logic [31:0] prio_w [NUM_PRIO_WORDS];
    int fail_count, n_tests, cyc;
    int r_src [5] = '{0, 17, 40, 65, 15};
    logic [1:0] r_code [5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h2};
    logic [1:0] r_lvl [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1};
    logic [ADDR_W-1:0] r_ofs [5] = '{24'h000000, 24'h000022, 24'h000050,
        24'h000082, 24'h00001E};
    localparam logic [ADDR_W-1:0] BASE = 24'h0ABC00;

    pia_irq_arbiter pia_irq_arbiter_inst (.clk(clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_irq(src_irq),
        .core_min_level(core_min_level), .irq_req(irq_req),
        .irq_fast(irq_fast), .irq_level(irq_level),
        .irq_vector(irq_vector), .irq_addr(irq_addr));
    pia_core_model pia_core_model_inst (.clk(clk), .rstn(rstn),
        .irq_req(irq_req), .irq_fast(irq_fast), .irq_addr(irq_addr),
        .level_set(lvl), .core_min_level(core_min_level),
        .fetch_addr_q(fetch_addr), .fetch_fast_q(fetch_fast));

    // ==========================================================
    // Tasks
    task automatic report_and_stop();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Inputs are sampled at the edge, so values read here are pre-update.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic set_prio(input int s, input logic [1:0] c);
        prio_w[s / 16][2 * (s % 16) +: 2] = c;
        apb(1'b1, 8'(4 * (s / 16)), prio_w[s / 16]);
    endtask : set_prio

    task automatic put(input logic [NUM_SRC-1:0] v);
        @(posedge clk);
        src_irq <= v;
        repeat (3) @(posedge clk);
    endtask : put

    task automatic chk_irq(input logic r, input logic f, input logic [1:0] l,
                           input logic [VEC_W-1:0] v,
                           input logic [ADDR_W-1:0] a);
        chk("irq_req", 32'(r), 32'(irq_req));
        chk("irq_fast", 32'(f), 32'(irq_fast));
        chk("irq_level", 32'(l), 32'(irq_level));
        chk("irq_vector", 32'(v), 32'(irq_vector));
        chk("irq_addr", 32'(a), 32'(irq_addr));
    endtask : chk_irq

    // ==========================================================
    // Clock, timeout and main sequence
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        src_irq = '0;
        lvl = 2'h0;
        fail_count = 0;
        n_tests = 0;
        foreach (prio_w[i]) prio_w[i] = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        put({NUM_SRC{1'b1}});
        chk_irq(1'b0, 1'b0, 2'h0, 7'h00, 24'h000000);
        apb(1'b0, OFS_FAST0_MATCH, 32'h0);
        chk("match0 reset", 32'h7F, rd);
        apb(1'b1, OFS_VBA, 32'(BASE));
        for (int i = 0; i < 5; i++) begin
            set_prio(r_src[i], r_code[i]);
            put(NUM_SRC'(1) << r_src[i]);
            chk_irq(1'b1, 1'b0, r_lvl[i], 7'(r_src[i]),
                    BASE + r_ofs[i]);
        end
        put((NUM_SRC'(1) << 65) | (NUM_SRC'(1) << 40));
        chk_irq(1'b1, 1'b0, 2'h2, 7'd40, BASE + 24'd80);
        put((NUM_SRC'(1) << 15) | (NUM_SRC'(1) << 17));
        chk_irq(1'b1, 1'b0, 2'h1, 7'd15, BASE + 24'd30);
        put((NUM_SRC'(1) << 0) | (NUM_SRC'(1) << 3));
        chk_irq(1'b1, 1'b0, 2'h0, 7'd0, BASE);
        put(NUM_SRC'(1) << 3);
        chk_irq(1'b0, 1'b0, 2'h0, 7'h00, 24'h000000);
        @(posedge clk);
        lvl <= 2'h2;
        put(NUM_SRC'(1) << 17);
        chk("below core level", 32'h0, 32'(irq_req));
        lvl <= 2'h0;
        apb(1'b1, OFS_FAST1_MATCH, 32'd65);
        apb(1'b1, OFS_FAST1_LOW, 32'h1234);
        apb(1'b1, OFS_FAST1_HIGH, 32'h56);
        apb(1'b1, OFS_FAST0_MATCH, 32'd17);
        put(NUM_SRC'(1) << 17);
        chk_irq(1'b1, 1'b0, 2'h1, 7'd17, BASE + 24'd34);
        put(NUM_SRC'(1) << 65);
        chk_irq(1'b1, 1'b1, 2'h2, 7'd65, 24'h561234);
        @(posedge clk);
        chk("core fetch", 32'h561234, 32'(fetch_addr));
        chk("core fetch fast", 32'h1, 32'(fetch_fast));
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h0000E041, rd);
        apb(1'b1, OFS_FAST0_LOW, 32'h4321);
        apb(1'b1, OFS_FAST0_HIGH, 32'h65);
        set_prio(17, 2'h3);
        put(NUM_SRC'(1) << 17);
        chk_irq(1'b1, 1'b1, 2'h2, 7'h11, 24'h654321);
        apb(1'b1, 8'h01, 32'hFFFFFFFF);
        chk("unaligned err", 32'h1, 32'(err));
        apb(1'b0, OFS_PRIO0, 32'h0);
        chk("prio word 0", prio_w[0], rd);
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        foreach (prio_w[i]) prio_w[i] = '0;
        repeat (2) @(posedge clk);
        chk_irq(1'b0, 1'b0, 2'h0, 7'h00, 24'h000000);
        apb(1'b0, OFS_FAST1_MATCH, 32'h0);
        chk("match1 reset", 32'h7F, rd);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
